// *** tbrs_switch.sv ***
/*
 * Trigger bus routing switch top: Wishbone slave with a serial shift
 * register, a load strobe and the active routing register.
 * Assumes a classic Wishbone master on i_clock; trigger pins are async.
 */
// What this block does
// - Routes trigger lines both ways per pattern
// - Each serial write with byte lane 0 enabled shifts one bit in
// - Bit 0 is serial data; others unused
// - Strobe write copies chain into active routing
// - Strobe acts on any write access, ignores data
module tbrs_switch
    import tbrs_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_wb_cyc,
    input  wire logic                   i_wb_stb,
    input  wire logic                   i_wb_we,
    input  wire logic [ADDR_W+1:0]      i_wb_adr,
    input  wire logic [3:0]             i_wb_sel,
    input  wire logic [31:0]            i_wb_dat,
    output logic      [31:0]            o_wb_dat,
    output logic                        o_wb_ack,
    input  wire logic [BOARD_LINES-1:0] i_board,
    input  wire logic [TRIG_LINES-1:0]  i_trig,
    output logic      [TRIG_LINES-1:0]  o_trig,
    output logic      [TRIG_LINES-1:0]  o_trig_oe,
    output logic      [3:0]             o_board
);

    tbrs_wb_req_t           req;
    logic [CHAIN_LEN-1:0]   chain;
    logic [CHAIN_LEN-1:0]   active;
    logic [5:0]             shift_count;
    logic [TRIG_LINES-1:0]  trig_meta;
    logic [TRIG_LINES-1:0]  trig_sync;
    logic                   access;
    logic                   wr;
    logic [ADDR_W-1:0]      index;
    logic [31:0]            next_dat;
    logic                   hit_serial;
    logic                   hit_strobe;

    assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we,
                   adr: i_wb_adr, sel: i_wb_sel, dat: i_wb_dat};
    assign index  = req.adr[ADDR_W+1:2];
    // One ack per request; the second cycle of a held request is idle.
    assign access = req.cyc & req.stb & ~o_wb_ack;
    assign wr     = access & req.we;
    // A serial write counts only when byte lane 0 carries the bit.
    assign hit_serial = wr & (index == IDX_SERIAL_INPUT) & req.sel[0];
    assign hit_strobe = wr & (index == IDX_LOAD_STROBE);

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            trig_meta <= 7'h00;
            trig_sync <= 7'h00;
        end
        else
        begin
            trig_meta <= i_trig;
            trig_sync <= trig_meta;
        end
    end

    // New bit enters at the bottom; byte lane 0 must be enabled.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            chain <= ROUTE_RESET;
        end
        else if (hit_serial)
        begin
            chain <= {chain[CHAIN_LEN-2:0],
                      req.dat[SERIAL_BIT_POS]};
        end
    end

    // The count saturates at the chain length; the strobe clears it.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            shift_count <= COUNT_RESET;
        end
        else if (hit_strobe)
        begin
            shift_count <= COUNT_RESET;
        end
        else if (hit_serial && shift_count != 6'(CHAIN_LEN))
        begin
            shift_count <= shift_count + 6'h01;
        end
    end

    // Only the strobe access updates the active pattern.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            active <= ROUTE_RESET;
        end
        else if (hit_strobe)
        begin
            active <= chain;
        end
    end

    always_comb
    begin
        next_dat = READ_ZERO;
        case (index)
            IDX_SHIFT_COUNT: next_dat = {26'h0, shift_count};
            IDX_ACTIVE_LO:   next_dat = active[31:0];
            IDX_ACTIVE_HI:   next_dat = {8'h00, active[CHAIN_LEN-1:32]};
            IDX_PENDING_LO:  next_dat = chain[31:0];
            IDX_PENDING_HI:  next_dat = {8'h00, chain[CHAIN_LEN-1:32]};
            default:         next_dat = READ_ZERO;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= READ_ZERO;
        end
        else
        begin
            o_wb_ack <= access;
            o_wb_dat <= (access && !req.we) ? next_dat : READ_ZERO;
        end
    end

    tbrs_crossbar u_crossbar
    (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_route   (tbrs_route_t'(active)),
        .i_board   (i_board),
        .i_trig    (trig_sync),
        .o_trig    (o_trig),
        .o_trig_oe (o_trig_oe),
        .o_board   (o_board)
    );

endmodule // tbrs_switch

// *** tbrs_pkg.sv ***
/*
 * Package for the trigger bus routing switch: register offsets, field
 * positions, reset values and the carrier structs shared by the design.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package tbrs_pkg;

    localparam int unsigned CHAIN_LEN       = 56;
    localparam int unsigned TRIG_LINES      = 7;
    localparam int unsigned BOARD_LINES     = 8;
    localparam int unsigned ADDR_W          = 8;

    // Printed offsets are indices; the byte address is four times each.
    localparam logic [ADDR_W-1:0] IDX_SERIAL_INPUT = 8'h0c;
    localparam logic [ADDR_W-1:0] IDX_LOAD_STROBE  = 8'h0e;
    localparam logic [ADDR_W-1:0] IDX_SHIFT_COUNT  = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_ACTIVE_LO    = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_ACTIVE_HI    = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_PENDING_LO   = 8'h13;
    localparam logic [ADDR_W-1:0] IDX_PENDING_HI   = 8'h14;

    localparam int unsigned SERIAL_BIT_POS  = 0;
    localparam logic [CHAIN_LEN-1:0] ROUTE_RESET = 56'h00000000000000;
    localparam logic [5:0]  COUNT_RESET     = 6'h00;
    localparam logic [31:0] READ_ZERO       = 32'h00000000;

    // One routing pattern: per trigger line, a drive enable onto the line,
    // a 3-bit board source, and a 4-bit listen mask toward the board.
    typedef struct packed {
        logic [TRIG_LINES-1:0]      drive_en;
        logic [TRIG_LINES*3-1:0]    drive_sel;
        logic [TRIG_LINES*4-1:0]    listen_mask;
    } tbrs_route_t;

    typedef struct packed {
        logic                       cyc;
        logic                       stb;
        logic                       we;
        logic [ADDR_W+1:0]          adr;
        logic [3:0]                 sel;
        logic [31:0]                dat;
    } tbrs_wb_req_t;

endpackage

// *** tbrs_crossbar.sv ***
/*
 * Routing crossbar: drives trigger lines from board signals and returns
 * trigger line levels to board signals under a routing pattern.
 * Assumes inputs are already synchronised to the local clock.
 */
module tbrs_crossbar
    import tbrs_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    input  wire tbrs_route_t            i_route,
    input  wire logic [BOARD_LINES-1:0] i_board,
    input  wire logic [TRIG_LINES-1:0]  i_trig,
    output logic      [TRIG_LINES-1:0]  o_trig,
    output logic      [TRIG_LINES-1:0]  o_trig_oe,
    output logic      [3:0]             o_board
);

    logic [TRIG_LINES-1:0] next_trig;
    logic [3:0]            listen [TRIG_LINES];
    logic [3:0]            next_board;

    genvar g;
    generate
        for (g = 0; g < TRIG_LINES; g++)
        begin : g_line
            assign next_trig[g] = i_board[i_route.drive_sel[g*3 +: 3]];
            assign listen[g] = i_route.listen_mask[g*4 +: 4]
                               & {4{i_trig[g] & ~i_route.drive_en[g]}};
        end
    endgenerate

    always_comb
    begin
        next_board = 4'h0;
        for (int k = 0; k < TRIG_LINES; k++)
        begin
            next_board = next_board | listen[k];
        end
    end

    // Both directions follow the active pattern only.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_trig    <= 7'h00;
            o_trig_oe <= 7'h00;
            o_board   <= 4'h0;
        end
        else
        begin
            o_trig    <= next_trig;
            o_trig_oe <= i_route.drive_en;
            o_board   <= next_board;
        end
    end

endmodule // tbrs_crossbar

// *** tbrs_peer.sv ***
/* Peer board on the trigger bus.
   Assumes the bench sets its level and drive per line. */
module tbrs_peer
(
    input  wire logic [6:0] i_level,
    input  wire logic [6:0] i_drive_en,
    input  wire logic [6:0] i_dut,
    input  wire logic [6:0] i_dut_oe,
    output logic      [6:0] o_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    // A line left free by all shows the inverse of the peer's level.
    assign o_wire = i_dut_oe & i_dut | ~i_dut_oe & ~(i_drive_en ^ i_level);
endmodule // tbrs_peer

// *** tbrs_checker.sv ***
/* Assertions on bus answers and routing hold of the switch.
   Bound to tbrs_switch; sees only its ports. */
module tbrs_checker
    import tbrs_pkg::*;
(
    input wire logic              i_clock,
    input wire logic              i_reset_n,
    input wire logic              i_wb_cyc,
    input wire logic              i_wb_stb,
    input wire logic              i_wb_we,
    input wire logic [ADDR_W+1:0] i_wb_adr,
    input wire logic [31:0]       o_wb_dat,
    input wire logic              o_wb_ack,
    input wire logic [6:0]        o_trig_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire logic tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic st = tk && i_wb_we && i_wb_adr[9:2] == IDX_LOAD_STROBE;
    sequence s_wr(a); tk && i_wb_we && i_wb_adr[9:2] == a; endsequence
    sequence s_pulse; o_wb_ack ##1 !o_wb_ack; endsequence
    property p_ser; s_wr(IDX_SERIAL_INPUT) |=> s_pulse; endproperty
    a_ser: assert property (p_ser) else $error("shift no ack");
    property p_stb; s_wr(IDX_LOAD_STROBE) |=> s_pulse; endproperty
    a_stb: assert property (p_stb) else $error("load no ack");
    property p_cause; o_wb_ack |-> $past(tk); endproperty
    a_cause: assert property (p_cause) else $error("stray ack");
    property p_idle; !o_wb_ack |-> o_wb_dat == READ_ZERO; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_hold; !$past(st, 2) |-> $stable(o_trig_oe); endproperty
    a_hold: assert property (p_hold) else $error("route moved");
    property p_upd; $changed(o_trig_oe) |-> $past(o_wb_ack); endproperty
    a_upd: assert property (p_upd) else $error("late route");
endmodule // tbrs_checker
bind tbrs_switch tbrs_checker tbrs_checker_inst
(
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_wb_cyc  (i_wb_cyc),
    .i_wb_stb  (i_wb_stb),
    .i_wb_we   (i_wb_we),
    .i_wb_adr  (i_wb_adr),
    .o_wb_dat  (o_wb_dat),
    .o_wb_ack  (o_wb_ack),
    .o_trig_oe (o_trig_oe)
);

// *** tb_top.sv ***
/* Bench for the routing switch: bus tasks, read queue, peer board.
   Assumes tbrs_checker binds itself. */
module tb_top
    import tbrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk = 0, rst_n = 0, ack;
    tbrs_wb_req_t req = '0;
    logic [31:0]  rdat, eq[$];
    logic [7:0]   brd = '0;
    logic [6:0]   lvl = '0, pen = '0, tro, toe, tw, et;
    logic [3:0]   bo, eb;
    logic [55:0]  pat, old = '0;
    tbrs_route_t  rt;
    int           n_fail = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    tbrs_switch tbrs_switch_inst (.i_clock(clk), .i_reset_n(rst_n),
        .i_wb_cyc(req.cyc), .i_wb_stb(req.stb), .i_wb_we(req.we),
        .i_wb_adr(req.adr), .i_wb_sel(req.sel), .i_wb_dat(req.dat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_board(brd), .i_trig(tw),
        .o_trig(tro), .o_trig_oe(toe), .o_board(bo));
    tbrs_peer tbrs_peer_inst (.i_level(lvl), .i_drive_en(pen),
        .i_dut(tro), .i_dut_oe(toe), .o_wire(tw));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        n_fail += int'(s !== e);
        if (s !== e)
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    endtask
    task automatic give_verdict(int extra);
        n_fail += extra;
        $display("%0d checks, %0d failed", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
        int k;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, {a, 2'b00}, s, d};
        for (k = 0; k < 20 && ack !== 1'b1; k++)
            @(posedge clk);
        if (k == 20)
            give_verdict(1);
        req <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        eq.push_back(e);
        wb(1'b0, a, $urandom, 4'hf);
    endtask
    always @(posedge clk)
        if (ack === 1'b1 && req.we === 1'b0)
            chk("read", rdat, eq.pop_front());
    initial
    begin
        void'($urandom(32'h9516));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h20, 32'h0);
        $display("unmapped test done");
        repeat (2)
        begin
            pat = {24'($urandom), 32'($urandom)};
            for (int i = 55; i >= 0; i--)
                wb(1'b1, IDX_SERIAL_INPUT, {31'($urandom), pat[i]}, 4'h1);
            rd(IDX_SHIFT_COUNT, 32'h38);
            // Lane 0 off and an unmapped index: neither may shift.
            wb(1'b1, IDX_SERIAL_INPUT, 32'($urandom), 4'he);
            wb(1'b1, 8'h20, 32'($urandom), 4'hf);
            rd(IDX_PENDING_HI, {8'h00, pat[55:32]});
            rd(IDX_PENDING_LO, pat[31:0]);
            rd(IDX_ACTIVE_LO, old[31:0]);
            rd(IDX_ACTIVE_HI, {8'h00, old[55:32]});
            brd <= 8'($urandom);
            lvl <= 7'($urandom);
            pen <= 7'($urandom);
            wb(1'b1, IDX_LOAD_STROBE, $urandom, 4'($urandom));
            rd(IDX_ACTIVE_LO, pat[31:0]);
            rd(IDX_ACTIVE_HI, {8'h00, pat[55:32]});
            rd(IDX_SHIFT_COUNT, 32'h0);
            rt = pat;
            et = '0;
            eb = '0;
            for (int g = 0; g < 7; g++)
            begin
                et[g] = rt.drive_en[g] & brd[rt.drive_sel[3*g+:3]];
                if (!rt.drive_en[g] && (pen[g] ~^ lvl[g]))
                    eb = eb | rt.listen_mask[4*g+:4];
            end
            chk("drive enable", 32'(toe), 32'(rt.drive_en));
            chk("drive value", 32'(tro & toe), 32'(et));
            chk("board input", 32'(bo), 32'(eb));
            old = pat;
            $display("pattern load test done");
        end
        give_verdict(0);
    end
endmodule // tb_top
